// *** verilog/spwm_pkg.sv ***
// Constants shared by the stretched 8-bit pulse generator
package spwm_pkg;

  localparam int AXI_AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DUTY = 8'hf2;
  localparam logic [7:0] IDX_CTRL = 8'hf3;
  localparam logic [7:0] IDX_STAT = 8'hf4;
  localparam logic [7:0] IDX_CLR  = 8'hf5;
  localparam logic [7:0] IDX_IEN  = 8'hf6;

  // Control register fields
  localparam int CTL_PEND = 0;
  localparam int CTL_IE   = 1;
  localparam int CTL_RUN  = 2;
  localparam int CTL_CLR  = 3;
  localparam int CTL_RLD  = 4;
  localparam int CTL_SEL  = 6;

  // Duty register fields
  localparam int DUTY_EXT = 0;
  localparam int DUTY_REF = 2;

  // Event bits of status, clear and enable registers
  localparam int EV_OVF   = 0;
  localparam int EV_FRAME = 1;
  localparam int EV_W     = 2;

  // Reset values
  localparam logic [7:0]      CTL_RESET  = 8'h00;
  localparam logic [7:0]      DUTY_RESET = 8'h00;
  localparam logic [EV_W-1:0] STAT_RESET = 2'h0;
  localparam logic [EV_W-1:0] IEN_RESET  = 2'h0;

  // Counter clock selections
  localparam logic [1:0] SEL_DIV64 = 2'h0;
  localparam logic [1:0] SEL_DIV8  = 2'h1;
  localparam logic [1:0] SEL_DIV2  = 2'h2;
  localparam logic [1:0] SEL_DIV1  = 2'h3;

  // Duty reload intervals
  localparam logic [1:0] RLD_FRAME = 2'h0;
  localparam logic [1:0] RLD_TWO   = 2'h1;
  localparam logic [1:0] RLD_FOUR  = 2'h2;
  localparam logic [1:0] RLD_NOW   = 2'h3;

  localparam logic [5:0] BASE_TOP = 6'h3f;
  localparam logic [7:0] CNT_TOP  = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verilog/spwm_top.sv ***
// Stretched 8-bit pulse generator with AXI4-Lite registers
//
// What this block does
// - Output falls when counter base bits equal the 6-bit reference.
// - Output rises on base overflow only when reference is non-zero.
// - Frame index bits against extension field pick the stretched frames.
// - A stretched frame stays high one counter clock longer; at reference 63 it never falls.
// - Codes 00 none, 01 frame 2, 10 frames 1,3, 11 frames 1-3.
// - Pulse passes through an output buffer flop to its pin.
// - Control holds clock select, reload interval, clear, run, interrupt.
// - Reset zeroes control: counter stopped, interrupt off, output idle.
// - Full 8-bit counter overflow raises the interrupt request.
// - Control bit 1 enables the overflow interrupt; software tests it first.
// - Control bit 0 is the pending flag; software clears it writing zero.
// - Control bit 2 runs counter and output; stop keeps the count.
// - Writing one to control bit 3 clears the counter.
// - Control bits 7:6 pick oscillator divided by 64, 8, 2 or 1.
// - Duty register: reference in bits 7:2, extension in bits 1:0.
`timescale 1ns/1ps

module spwm_top
  import spwm_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  output wire logic              pulse_output_pin,
  output wire logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_full;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        ctl;
    logic [7:0]        duty;
    logic [7:0]        act_duty;
    logic [EV_W-1:0]   ist;
    logic [EV_W-1:0]   ien;
    logic [DIV_W-1:0]  div;
    logic [7:0]        cnt;
    logic              pulse;
    logic              pin;
    logic              irq;
  } spwm_state_t;

  spwm_state_t s;
  spwm_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic reg_hit(input logic [AXI_AW-1:0] a,
                                   input logic [7:0]        idx);
    reg_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic tick_of(input logic [1:0]       sel,
                                   input logic [DIV_W-1:0] d);
    unique case (sel)
      SEL_DIV64: tick_of = &d;
      SEL_DIV8:  tick_of = &d[2:0];
      SEL_DIV2:  tick_of = d[0];
      SEL_DIV1:  tick_of = 1'b1;
    endcase
  endfunction

  // Frame index 0..3 stands for cycles 1..4 of the group
  function automatic logic stretch_of(input logic [1:0] ext,
                                      input logic [1:0] frame);
    unique case (ext)
      2'h0: stretch_of = 1'b0;
      2'h1: stretch_of = (frame == 2'h1);
      2'h2: stretch_of = ~frame[0];
      2'h3: stretch_of = (frame != 2'h3);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic            run;
  logic            tick;
  logic [7:0]      nc;
  logic            cnt_ovf;
  logic            frame_ovf;
  logic [5:0]      ref_now;
  logic            stretch_now;
  logic            hit_high;
  logic            hit_low;
  logic            wr_go;
  logic            wr_ctl;
  logic            clr_req;
  logic [EV_W-1:0] clr_mask;
  logic [EV_W-1:0] ev;
  logic            rld_due;

  assign run       = s.ctl[CTL_RUN];
  assign tick      = run & tick_of(s.ctl[CTL_SEL+:2], s.div);
  assign nc        = s.cnt + 8'h01;
  assign cnt_ovf   = tick & (s.cnt == CNT_TOP);
  assign frame_ovf = tick & (s.cnt[5:0] == BASE_TOP);
  assign ref_now   = s.act_duty[DUTY_REF+:6];
  assign stretch_now = stretch_of(s.act_duty[DUTY_EXT+:2], nc[7:6]);
  assign hit_high  = (nc[5:0] == 6'h00) & (ref_now != 6'h00);
  // One count later in a stretched frame; ref 63 plus one never matches
  assign hit_low   = ({1'b0, nc[5:0]} ==
                      ({1'b0, ref_now} + {6'h00, stretch_now}));
  assign wr_go     = s.aw_full & s.w_full & ~s.bvalid;
  assign wr_ctl    = wr_go & s.w_lane0 & reg_hit(s.aw_addr, IDX_CTRL);
  assign clr_req   = wr_ctl & s.w_data[CTL_CLR];
  assign clr_mask  = (wr_go & s.w_lane0 & reg_hit(s.aw_addr, IDX_CLR))
                     ? s.w_data[EV_W-1:0] : '0;
  assign ev        = {frame_ovf, cnt_ovf};

  always_comb begin
    unique case (s.ctl[CTL_RLD+:2])
      RLD_FRAME: rld_due = frame_ovf;
      RLD_TWO:   rld_due = frame_ovf & ~nc[6];
      RLD_FOUR:  rld_due = cnt_ovf;
      RLD_NOW:   rld_due = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;

    // Write channels are latched independently, in either order
    if (s.awready & awvalid) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (s.wready & wvalid) begin
      next_s.w_full  = 1'b1;
      next_s.w_data  = wdata[7:0];
      next_s.w_lane0 = wstrb[0];
    end
    if (s.bvalid & bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      if (!(reg_hit(s.aw_addr, IDX_DUTY) | reg_hit(s.aw_addr, IDX_CTRL) |
            reg_hit(s.aw_addr, IDX_STAT) | reg_hit(s.aw_addr, IDX_CLR) |
            reg_hit(s.aw_addr, IDX_IEN))) begin
        next_s.bresp = RESP_SLVERR;
      end else if (s.w_lane0) begin
        if (reg_hit(s.aw_addr, IDX_DUTY)) begin
          next_s.duty = s.w_data;
        end
        if (reg_hit(s.aw_addr, IDX_IEN)) begin
          next_s.ien = s.w_data[EV_W-1:0];
        end
      end
    end
    // Clear bit is a strobe and always reads back zero
    if (wr_ctl) begin
      next_s.ctl = {s.w_data[7:4], 1'b0, s.w_data[CTL_RUN:CTL_IE],
                    s.ctl[CTL_PEND] & s.w_data[CTL_PEND]};
    end
    // Overflow beats a software clear in the same cycle
    next_s.ctl[CTL_PEND] = next_s.ctl[CTL_PEND] | cnt_ovf;
    next_s.ist = (s.ist & ~clr_mask) | ev;

    // Read channel
    if (s.arready & arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      if (reg_hit(araddr, IDX_DUTY)) begin
        next_s.rdata[7:0] = s.duty;
      end else if (reg_hit(araddr, IDX_CTRL)) begin
        next_s.rdata[7:0] = s.ctl;
      end else if (reg_hit(araddr, IDX_STAT)) begin
        next_s.rdata[EV_W-1:0] = s.ist;
      end else if (reg_hit(araddr, IDX_IEN)) begin
        next_s.rdata[EV_W-1:0] = s.ien;
      end else if (!reg_hit(araddr, IDX_CLR)) begin
        next_s.rresp = RESP_SLVERR;
      end
    end else if (s.rvalid & rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.awready = ~next_s.aw_full;
    next_s.wready  = ~next_s.w_full;
    next_s.arready = ~next_s.rvalid;

    // Counter and pulse
    if (clr_req) begin
      next_s.cnt   = 8'h00;
      next_s.div   = '0;
      next_s.pulse = 1'b0;
    end else if (run) begin
      next_s.div = s.div + DIV_W'(1);
      if (tick) begin
        next_s.cnt = nc;
        if (hit_high) begin
          next_s.pulse = 1'b1;
        end else if (hit_low) begin
          next_s.pulse = 1'b0;
        end
      end
    end else begin
      next_s.pulse = 1'b0;
    end
    // Duty takes effect at the reload point picked by control bits 5:4; RLD_NOW and a clear load it at once
    if (rld_due | clr_req) begin
      next_s.act_duty = next_s.duty;
    end
    next_s.pin = s.pulse;
    next_s.irq = (next_s.ctl[CTL_IE] & next_s.ctl[CTL_PEND]) |
                 (|(next_s.ist & next_s.ien));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.ctl  <= CTL_RESET;
      s.duty <= DUTY_RESET;
      s.act_duty <= DUTY_RESET;
      s.ist  <= STAT_RESET;
      s.ien  <= IEN_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign awready          = s.awready;
  assign wready           = s.wready;
  assign arready          = s.arready;
  assign bvalid           = s.bvalid;
  assign bresp            = s.bresp;
  assign rvalid           = s.rvalid;
  assign rdata            = s.rdata;
  assign rresp            = s.rresp;
  assign pulse_output_pin = s.pin;
  assign irq              = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  low_on_match_a: assert property (
    tick && !clr_req && hit_low && !hit_high |=> !s.pulse)
    else $error("pulse did not fall on reference match");

  high_on_wrap_a: assert property (
    tick && !clr_req && hit_high |=> s.pulse)
    else $error("pulse did not rise on base overflow");

  stretch_hold_a: assert property (
    tick && !clr_req && stretch_now && ref_now != 6'h00 && s.pulse &&
    nc[5:0] == ref_now |=> s.pulse)
    else $error("stretched frame fell too early");

  frame_one_a: assert property (
    tick && !clr_req && s.act_duty[1:0] == 2'h1 && nc[7:6] == 2'h0 &&
    ref_now != 6'h00 && nc[5:0] == ref_now |=> !s.pulse)
    else $error("frame 1 stretched with code 01");

  pin_buffer_a: assert property (
    s.pulse |=> s.pin)
    else $error("pin does not follow buffered pulse");

  stop_hold_a: assert property (
    !run && !clr_req |=> $stable(s.cnt) && !s.pulse)
    else $error("stopped counter moved");

  clear_cnt_a: assert property (
    clr_req |=> s.cnt == 8'h00 && s.div == '0)
    else $error("counter clear failed");

  div64_rate_a: assert property (
    run && s.ctl[CTL_SEL+:2] == SEL_DIV64 && tick |-> s.div == 6'h3f)
    else $error("divide by 64 tick misplaced");

  pend_set_a: assert property (
    cnt_ovf |=> s.ctl[CTL_PEND] && s.ist[EV_OVF])
    else $error("overflow did not set pending");

  irq_raise_a: assert property (
    cnt_ovf && s.ctl[CTL_IE] && !wr_ctl |=> s.irq)
    else $error("enabled overflow gave no interrupt");

  wrap_zero_a: assert property (
    cnt_ovf && !clr_req |=> s.cnt == 8'h00)
    else $error("counter did not wrap to zero");

  bresp_hold_a: assert property (
    s.bvalid && !bready |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped early");

endmodule

// *** verif/spwm_load.sv ***
// External load on the pulse pin: measures each high time in clocks
`timescale 1ns/1ps
module spwm_load (
  input wire logic aclk,
  input wire logic pulse_output_pin
);
  int hi = 0;
  int lens[$];
  // The pin is a driven level, so a pulse ends on the first low sample
  always @(posedge aclk) begin
    if (pulse_output_pin === 1'b1) begin
      hi <= hi + 1;
    end else begin
      if (hi > 0) lens.push_back(hi);
      hi <= 0;
    end
  end
endmodule

// *** verif/spwm_top_tb.sv ***
// Self-checking bench for the stretched pulse generator
`timescale 1ns/1ps
module spwm_top_tb;
  import spwm_pkg::*;
  localparam logic [11:0] A_DUTY = {2'h0, IDX_DUTY, 2'h0};
  localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, IDX_STAT, 2'h0};
  localparam logic [11:0] A_CLR  = {2'h0, IDX_CLR, 2'h0};
  localparam logic [11:0] A_IEN  = {2'h0, IDX_IEN, 2'h0};
  logic              aclk = 0;
  logic              aresetn = 0;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic              awvalid = 0;
  logic              wvalid = 0;
  logic              bready = 0;
  logic              arvalid = 0;
  logic              rready = 0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = '0;
  wire logic         awready, wready, bvalid, arready, rvalid, pin, irq;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  int                bad_count = 0;
  int                n_tests = 0;
  int                cycles = 0;
  logic [7:0]        rd;
  logic [7:0]        wv;
  logic [1:0]        rs;

  spwm_top spwm_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pulse_output_pin(pin), .irq(irq));
  spwm_load spwm_load_i (.aclk(aclk), .pulse_output_pin(pin));

  always #20 aclk = ~aclk;
  // Longest run is the divide-by-64 case, about 16500 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] x, input string m);
    n_tests++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, s, x);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each channel is released at the edge where its own ready is seen
  task wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  task rdr(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 0;
  endtask
  function automatic int stretch(input logic [1:0] ext, input int f);
    case (ext)
      2'h1: return int'(f == 1);
      2'h2: return int'(f == 0 || f == 2);
      2'h3: return int'(f != 3);
      default: return 0;
    endcase
  endfunction
  function automatic int divof(input logic [1:0] sel);
    return sel == SEL_DIV64 ? 64 : sel == SEL_DIV8 ? 8 :
           sel == SEL_DIV2 ? 2 : 1;
  endfunction
  // Restart from a cleared counter; frame 0 has no rising edge, so the
  // first four pulses seen belong to frames 1, 2, 3 and 0
  task restart(input logic [1:0] sel, input logic [7:0] duty);
    wr(A_CTRL, 8'h00, rs);
    repeat (4) @(posedge aclk);
    spwm_load_i.lens.delete();
    wr(A_DUTY, duty, rs);
    wr(A_CTRL, {sel, RLD_NOW, 4'hc}, rs);
  endtask
  task pulses(input logic [1:0] sel, input logic [5:0] rf,
              input logic [1:0] ext);
    int e;
    restart(sel, {rf, ext});
    while (spwm_load_i.lens.size() < 4) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      e = (int'(rf) + stretch(ext, (i + 1) % 4)) * divof(sel);
      chk(spwm_load_i.lens[i], e, "high time");
    end
  endtask
  // Duty written in frame 0 takes effect from pulse k on (ref 10 -> 20)
  task reload(input logic [1:0] rld, input int k);
    restart(SEL_DIV1, 8'h28);
    wr(A_CTRL, {SEL_DIV1, rld, 4'h4}, rs);
    wr(A_DUTY, 8'h50, rs);
    while (spwm_load_i.lens.size() < 4) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      chk(spwm_load_i.lens[i], (i < k) ? 10 : 20, "reload point");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(89205));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk({irq, pin}, 2'h0, "outputs after reset");
    @(posedge aclk);
    chk({awready, wready, arready}, 3'h7, "readies after reset");
    for (int i = 0; i < 5; i++) begin
      rdr({2'h0, IDX_DUTY + 8'(i), 2'h0}, rd, rs);
      chk({rs, rd}, 10'h0, "reset value");
    end
    rdr(12'h3e0, rd, rs);
    chk(rs, RESP_SLVERR, "unmapped read");
    wr(12'h3e0, 8'hff, rs);
    chk(rs, RESP_SLVERR, "unmapped write");
    wv = 8'($urandom);
    wr(A_DUTY, wv, rs);
    chk(rs, RESP_OKAY, "mapped write");
    rdr(A_DUTY, rd, rs);
    chk(rd, wv, "duty readback");
    wr(A_CTRL, 8'hf2, rs);
    rdr(A_CTRL, rd, rs);
    chk(rd, 8'hf2, "control readback");
    for (int x = 0; x < 4; x++) pulses(SEL_DIV1, 6'($urandom_range(62, 1)),
                                       2'(x));
    pulses(SEL_DIV2, 6'h01, 2'h3);
    pulses(SEL_DIV8, 6'($urandom_range(20, 1)), 2'h2);
    pulses(SEL_DIV64, 6'h02, 2'h1);
    reload(RLD_FRAME, 0);
    reload(RLD_TWO, 1);
    reload(RLD_FOUR, 3);
    restart(SEL_DIV1, 8'h03);
    repeat (300) @(posedge aclk);
    chk(spwm_load_i.lens.size(), 0, "zero reference");
    // Overflow of the full count arrives 256 clocks after a clear
    wr(A_CTRL, {SEL_DIV1, RLD_NOW, 4'he}, rs);
    repeat (240) @(posedge aclk);
    chk(irq, 1'b0, "early interrupt");
    while (irq !== 1'b1) @(posedge aclk);
    rdr(A_CTRL, rd, rs);
    chk(rd[CTL_IE], 1'b1, "enable seen");
    chk(rd[CTL_PEND], 1'b1, "pending seen");
    wr(A_CTRL, rd & 8'hf2, rs);
    repeat (3) @(posedge aclk);
    chk({irq, pin}, 2'h0, "pending cleared, stopped");
    rdr(A_STAT, rd, rs);
    chk(rd[EV_OVF], 1'b1, "status overflow");
    wr(A_IEN, 8'h01, rs);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1, "status interrupt");
    wr(A_CLR, 8'h01, rs);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0, "status cleared");
    results();
  end
endmodule
